// file: hdl/sls_pkg.sv
// constants, types and carriers shared by the stroke limit stop logic
// Functional notes
// - limit input is normally closed; closed means released, open means active.
// - active limit raises its warning and stops the motor by configured method.
// - forward limit guards positive travel, reverse limit guards negative travel.
// - stop method select: 0 quick stop (reset default), 1 slow stop.
// - auto-on select treats both limits as always released; default 0 uses inputs.
// - torque mode ignores limits, except linear motors during pole detection.
// - pole detection limit select: 0 honours limits there (default), 1 ignores.
// - while limited, position commands away from the limit are accepted.
// - in speed mode, speed commands away from the limit are accepted.
// - a limit stop may invalidate home; controller must home again.
// - each limit function can be routed to any digital input pin.
package sls_pkg;
   // ==========================================================
   // timing
   localparam int CLK_MHZ     = 250;
   localparam int DEB_TIME_US = 1000;
   localparam int DEB_CYC     = DEB_TIME_US * CLK_MHZ;
   localparam int CNT_W       = 18;
   // ==========================================================
   // sizes
   localparam int NUM_PINS = 8;
   localparam int PIN_W    = 3;
   localparam int ADDR_W   = 8;
   localparam int IRQ_W    = 3;
   // ==========================================================
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ISTAT  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IMASK  = 8'h0C;
   // ==========================================================
   // control field positions and reset values
   localparam int CTRL_STOP_SLOW = 0;
   localparam int CTRL_WARN_OFF  = 1;
   localparam int CTRL_AUTO_ON   = 2;
   localparam int CTRL_POLE_OFF  = 3;
   localparam int CTRL_FWD_PIN   = 8;
   localparam int CTRL_REV_PIN   = 12;
   localparam logic [PIN_W-1:0] FWD_PIN_RST = 3'h0;
   localparam logic [PIN_W-1:0] REV_PIN_RST = 3'h1;
   // ==========================================================
   // status and interrupt bit positions
   localparam int ST_FWD_ACT   = 0;
   localparam int ST_REV_ACT   = 1;
   localparam int ST_FWD_WARN  = 2;
   localparam int ST_REV_WARN  = 3;
   localparam int ST_STOP      = 4;
   localparam int ST_HOME_LOST = 5;
   localparam int ST_FWD_PIN   = 8;
   localparam int ST_REV_PIN   = 9;
   localparam int IRQ_FWD      = 0;
   localparam int IRQ_REV      = 1;
   localparam int IRQ_HOME     = 2;
   // ==========================================================
   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      MODE_POS    = 2'b00,
      MODE_SPEED  = 2'b01,
      MODE_TORQUE = 2'b10
   } sls_mode_t;

   typedef struct packed {
      logic             stop_slow;
      logic             warn_off;
      logic             auto_on;
      logic             pole_off;
      logic [PIN_W-1:0] fwd_pin;
      logic [PIN_W-1:0] rev_pin;
   } sls_cfg_t;

   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } sls_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } sls_axi_rsp_t;
endpackage

// file: hdl/sls_pin_route.sv
// routes one chosen digital input pin to a limit function
`timescale 1ns/100ps
`default_nettype none
module sls_pin_route
   import sls_pkg::*;
(
   // clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                ce,
   // pins and selection
   input  wire logic [NUM_PINS-1:0] pins,
   input  wire logic [PIN_W-1:0]    sel,
   // routed level
   output logic                     pin_out
);
   typedef struct packed {
      logic pin;
   } sls_route_st_t;

   sls_route_st_t s;
   sls_route_st_t next_s;

   // ==========================================================
   // selection mux, registered
   always_comb
   begin
      next_s     = s;
      next_s.pin = pins[sel];
   end

   // reset to closed so no false limit right after reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s <= '1;
      else if (ce)
         s <= next_s;
   end

   assign pin_out = s.pin;
endmodule
`default_nettype wire

// file: hdl/sls_debounce.sv
// synchroniser and bounce filter for one limit contact
`timescale 1ns/100ps
`default_nettype none
module sls_debounce
   import sls_pkg::*;
#(
   parameter int DEB_COUNT = DEB_CYC
)
(
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   // contact
   input  wire logic raw,
   output logic      filt
);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(DEB_COUNT - 1);

   typedef struct packed {
      logic             s1;
      logic             s2;
      logic [CNT_W-1:0] cnt;
      logic             filt;
   } sls_deb_st_t;

   sls_deb_st_t s;
   sls_deb_st_t next_s;

   // ==========================================================
   // new level must hold a full filter time before it is taken
   always_comb
   begin
      next_s    = s;
      next_s.s1 = raw;
      next_s.s2 = s.s1;
      if (s.s2 == s.filt)
         next_s.cnt = '0;
      else if (s.cnt == LAST)
      begin
         next_s.filt = s.s2;
         next_s.cnt  = '0;
      end
      else
         next_s.cnt = s.cnt + CNT_W'(1);
   end

   // resets closed (released); an open contact shows after one filter time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s      <= '0;
         s.s1   <= 1'b1;
         s.s2   <= 1'b1;
         s.filt <= 1'b1;
      end
      else if (ce)
         s <= next_s;
   end

   assign filt = s.filt;
endmodule
`default_nettype wire

// file: hdl/sls_top.sv
// stroke limit supervision with register slave and interrupt
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module sls_top
   import sls_pkg::*;
#(
   parameter int DEB_COUNT = DEB_CYC
)
(
   // clock, reset, enable
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                ce,
   // register bus
   input  wire sls_pkg::sls_axi_req_t axi_req,
   output sls_pkg::sls_axi_rsp_t    axi_rsp,
   // digital input pins of the io_connector
   input  wire logic [sls_pkg::NUM_PINS-1:0] io_connector,
   // drive state
   input  wire sls_pkg::sls_mode_t  ctl_mode,
   input  wire logic                motor_linear,
   input  wire logic                pole_detect_active,
   input  wire logic                homing_done,
   // motion commands
   input  wire logic                cmd_pos,
   input  wire logic                cmd_neg,
   output logic                     cmd_pos_ok,
   output logic                     cmd_neg_ok,
   // stop and warnings
   output logic                     stop_req,
   output logic                     stop_slow,
   output logic [1:0]               stroke_limit_warning,
   output logic                     home_lost,
   output logic                     irq
);
   import sls_pkg::*;

   typedef struct packed {
      sls_cfg_t          cfg;
      logic [IRQ_W-1:0]  ist;
      logic [IRQ_W-1:0]  imask;
      logic              aw_ok;
      logic [ADDR_W-1:0] awa;
      logic              w_ok;
      logic [31:0]       wd;
      logic [3:0]        ws;
      logic              bv;
      logic [1:0]        br;
      logic              rv;
      logic [31:0]       rd;
      logic [1:0]        rr;
      logic [1:0]        eff_d;
      logic              stop;
      logic              home_lost;
      logic [1:0]        warn;
   } sls_main_st_t;

   sls_main_st_t s;
   sls_main_st_t next_s;

   logic [1:0]       closed;
   logic [1:0]       routed;
   logic [1:0][PIN_W-1:0] pin_sel;
   logic [1:0]       act;
   logic [1:0]       eff;
   logic [1:0]       hit;
   logic             hon;
   logic             wr_go;
   logic [IRQ_W-1:0] ev;
   logic [31:0]      clr;
   logic [31:0]      merged;

   // ==========================================================
   // byte-lane merge and control word packing
   function automatic logic [31:0] lane_merge(input logic [31:0] o,
                                              input logic [31:0] d,
                                              input logic [3:0]  b);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
         if (b[i])
            r[8*i +: 8] = d[8*i +: 8];
      return r;
   endfunction

   function automatic logic [31:0] ctrl_word(input sls_cfg_t c);
      logic [31:0] w;
      w = '0;
      w[CTRL_STOP_SLOW]             = c.stop_slow;
      w[CTRL_WARN_OFF]              = c.warn_off;
      w[CTRL_AUTO_ON]               = c.auto_on;
      w[CTRL_POLE_OFF]              = c.pole_off;
      w[CTRL_FWD_PIN +: PIN_W]      = c.fwd_pin;
      w[CTRL_REV_PIN +: PIN_W]      = c.rev_pin;
      return w;
   endfunction

   function automatic sls_cfg_t ctrl_unpack(input logic [31:0] w);
      sls_cfg_t c;
      c.stop_slow = w[CTRL_STOP_SLOW];
      c.warn_off  = w[CTRL_WARN_OFF];
      c.auto_on   = w[CTRL_AUTO_ON];
      c.pole_off  = w[CTRL_POLE_OFF];
      c.fwd_pin   = w[CTRL_FWD_PIN +: PIN_W];
      c.rev_pin   = w[CTRL_REV_PIN +: PIN_W];
      return c;
   endfunction

   // ==========================================================
   // per-channel pin routing and contact filtering; index 0 forward
   assign pin_sel[0] = s.cfg.fwd_pin;
   assign pin_sel[1] = s.cfg.rev_pin;

   for (genvar g = 0; g < 2; g++)
   begin : g_chan
      sls_pin_route u_route (
         .aclk    (aclk),
         .aresetn (aresetn),
         .ce      (ce),
         .pins    (io_connector),
         .sel     (pin_sel[g]),
         .pin_out (routed[g])
      );
      sls_debounce #(.DEB_COUNT(DEB_COUNT)) u_deb (
         .aclk    (aclk),
         .aresetn (aresetn),
         .ce      (ce),
         .raw     (routed[g]),
         .filt    (closed[g])
      );
   end

   // ==========================================================
   // limit qualification
   always_comb
   begin
      // open contact means limit in progress, unless forced on
      act = ~closed & {2{~s.cfg.auto_on}};
      unique case (ctl_mode)
         MODE_POS,
         MODE_SPEED:  hon = 1'b1;
         MODE_TORQUE: hon = motor_linear & pole_detect_active;
         default:     hon = 1'b1; // unknown mode: stay protected
      endcase
      if (pole_detect_active && s.cfg.pole_off)
         hon = 1'b0;
      eff = act & {2{hon}};
      hit = eff & ~s.eff_d;
   end

   // ==========================================================
   // interrupt events
   assign ev[IRQ_FWD]  = hit[0];
   assign ev[IRQ_REV]  = hit[1];
   assign ev[IRQ_HOME] = (|hit) & ~s.cfg.stop_slow & ~s.home_lost;
   assign wr_go        = s.aw_ok & s.w_ok & ~s.bv;
   assign merged       = lane_merge(s.awa == OFS_CTRL ? ctrl_word(s.cfg) :
                                    {{(32-IRQ_W){1'b0}}, s.imask}, s.wd, s.ws);
   assign clr          = (wr_go && s.awa == OFS_ISTAT) ?
                         lane_merge('0, s.wd, s.ws) : '0;

   // ==========================================================
   // next state: bus channels, registers, limit reaction
   always_comb
   begin
      next_s = s;
      // write address and data taken in either order
      if (axi_req.awvalid && !s.aw_ok && !s.bv)
      begin
         next_s.aw_ok = 1'b1;
         next_s.awa   = axi_req.awaddr[ADDR_W-1:0];
      end
      if (axi_req.wvalid && !s.w_ok && !s.bv)
      begin
         next_s.w_ok = 1'b1;
         next_s.wd   = axi_req.wdata;
         next_s.ws   = axi_req.wstrb;
      end
      if (s.bv && axi_req.bready)
         next_s.bv = 1'b0;
      if (wr_go)
      begin
         next_s.aw_ok = 1'b0;
         next_s.w_ok  = 1'b0;
         next_s.bv    = 1'b1;
         next_s.br    = RESP_OKAY;
         case (s.awa)
            OFS_CTRL:   next_s.cfg   = ctrl_unpack(merged);
            OFS_IMASK:  next_s.imask = merged[IRQ_W-1:0];
            OFS_ISTAT,
            OFS_STATUS: ;
            default:    next_s.br    = RESP_SLVERR;
         endcase
      end
      // read: one outstanding, data registered
      if (s.rv && axi_req.rready)
         next_s.rv = 1'b0;
      if (axi_req.arvalid && !s.rv)
      begin
         next_s.rv = 1'b1;
         next_s.rr = RESP_OKAY;
         next_s.rd = '0;
         case (axi_req.araddr[ADDR_W-1:0])
            OFS_CTRL:   next_s.rd = ctrl_word(s.cfg);
            OFS_STATUS:
            begin
               next_s.rd[ST_FWD_ACT]   = s.eff_d[0];
               next_s.rd[ST_REV_ACT]   = s.eff_d[1];
               next_s.rd[ST_FWD_WARN]  = s.warn[0];
               next_s.rd[ST_REV_WARN]  = s.warn[1];
               next_s.rd[ST_STOP]      = s.stop;
               next_s.rd[ST_HOME_LOST] = s.home_lost;
               next_s.rd[ST_FWD_PIN]   = closed[0];
               next_s.rd[ST_REV_PIN]   = closed[1];
            end
            OFS_ISTAT:  next_s.rd[IRQ_W-1:0] = s.ist;
            OFS_IMASK:  next_s.rd[IRQ_W-1:0] = s.imask;
            default:    next_s.rr = RESP_SLVERR;
         endcase
      end
      // sticky events: a new event beats a clear in the same cycle
      next_s.ist   = (s.ist & ~clr[IRQ_W-1:0]) | ev;
      next_s.eff_d = eff;
      // warning follows the active limit unless silenced
      next_s.warn  = eff & {2{~s.cfg.warn_off}};
      // stop held until released or commanded away from the limit
      if (|hit)
         next_s.stop = 1'b1;
      else if (eff == 2'b00)
         next_s.stop = 1'b0;
      else if (eff == 2'b01 && cmd_neg && !cmd_pos)
         next_s.stop = 1'b0;
      else if (eff == 2'b10 && cmd_pos && !cmd_neg)
         next_s.stop = 1'b0;
      // quick stop discards home; homing clears it, a new loss wins
      if (homing_done)
         next_s.home_lost = 1'b0;
      if ((|hit) && !s.cfg.stop_slow)
         next_s.home_lost = 1'b1;
   end

   // ==========================================================
   // single state register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s             <= '0;
         s.cfg.fwd_pin <= FWD_PIN_RST;
         s.cfg.rev_pin <= REV_PIN_RST;
      end
      else if (ce)
         s <= next_s;
   end

   // ==========================================================
   // outputs; forward limit blocks positive travel only
   assign cmd_pos_ok           = cmd_pos & ~s.eff_d[0];
   assign cmd_neg_ok           = cmd_neg & ~s.eff_d[1];
   assign stop_req             = s.stop;
   assign stop_slow            = s.cfg.stop_slow;
   assign stroke_limit_warning = s.warn;
   assign home_lost            = s.home_lost;
   assign irq                  = |(s.ist & s.imask);

   assign axi_rsp.awready = ~s.aw_ok & ~s.bv;
   assign axi_rsp.wready  = ~s.w_ok & ~s.bv;
   assign axi_rsp.bvalid  = s.bv;
   assign axi_rsp.bresp   = s.br;
   assign axi_rsp.arready = ~s.rv;
   assign axi_rsp.rvalid  = s.rv;
   assign axi_rsp.rdata   = s.rd;
   assign axi_rsp.rresp   = s.rr;
endmodule
`default_nettype wire

// file: tb/sls_checker_assertions.sv
// port-level checker for the stroke limit supervision
`timescale 1ns/100ps
`default_nettype none
module sls_checker
   import sls_pkg::*;
#(
   parameter int DEB_COUNT = 4
)
(
   // clock and reset
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  ce,
   // register bus
   input wire sls_pkg::sls_axi_req_t axi_req,
   input wire sls_pkg::sls_axi_rsp_t axi_rsp,
   // drive state and commands
   input wire sls_pkg::sls_mode_t    ctl_mode,
   input wire logic                  homing_done,
   input wire logic                  cmd_pos,
   input wire logic                  cmd_neg,
   input wire logic                  cmd_pos_ok,
   input wire logic                  cmd_neg_ok,
   // stop and warnings
   input wire logic                  stop_req,
   input wire logic                  stop_slow,
   input wire logic [1:0]            stroke_limit_warning,
   input wire logic                  home_lost,
   input wire logic                  irq
);
   // ==========================================================
   // properties, all in the one clock domain
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_POS_OK: assert property (cmd_pos_ok |-> cmd_pos)
      else $error("positive grant without request");
   AST_NEG_OK: assert property (cmd_neg_ok |-> cmd_neg)
      else $error("negative grant without request");
   AST_FWD_BLOCK: assert property (stroke_limit_warning[0] && cmd_pos |-> !cmd_pos_ok)
      else $error("positive motion granted into forward limit");
   AST_REV_BLOCK: assert property (stroke_limit_warning[1] && cmd_neg |-> !cmd_neg_ok)
      else $error("negative motion granted into reverse limit");
   AST_WARN_STOP: assert property (|(stroke_limit_warning & ~$past(stroke_limit_warning))
      |-> stop_req)
      else $error("warning raised without stop");
   // a released limit drops stop and warning on the same edge; torque mode may drop it anytime
   AST_STOP_HOLD: assert property (stop_req && !cmd_pos && !cmd_neg && ce
      && |stroke_limit_warning && ctl_mode != MODE_TORQUE
      |=> stop_req || stroke_limit_warning == 2'b00)
      else $error("stop dropped while limit held and no command");
   AST_HOME_SLOW: assert property ($rose(home_lost) |-> !stop_slow)
      else $error("home lost on slow stop");
   AST_HOME_CLR: assert property ($fell(home_lost) |-> $past(homing_done) || !$past(aresetn))
      else $error("home loss cleared without homing");
   AST_RESET: assert property ($rose(aresetn) |-> axi_rsp.awready && axi_rsp.arready
      && !stop_req && !irq && !home_lost)
      else $error("bad state after reset");
   AST_RD_ANS: assert property (ce && axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("read answer late");
   AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid
      ##0 $stable(axi_rsp.bresp))
      else $error("write answer dropped early");
endmodule

bind sls_top sls_checker #(.DEB_COUNT(DEB_COUNT)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .ctl_mode(ctl_mode), .homing_done(homing_done), .cmd_pos(cmd_pos), .cmd_neg(cmd_neg),
   .cmd_pos_ok(cmd_pos_ok), .cmd_neg_ok(cmd_neg_ok), .stop_req(stop_req),
   .stop_slow(stop_slow), .stroke_limit_warning(stroke_limit_warning),
   .home_lost(home_lost), .irq(irq));
`default_nettype wire

// file: tb/sls_partner.sv
// limit switches and motion controller beside the block
`timescale 1ns/100ps
`default_nettype none
module sls_partner
   import sls_pkg::*;
(
   // clock
   input  wire logic                aclk,
   // wanted switch state and motion from the bench
   input  wire logic [NUM_PINS-1:0] sw_open,
   input  wire logic [1:0]          want,
   // lines to the block
   output logic [NUM_PINS-1:0]      io_connector,
   output logic                     cmd_pos,
   output logic                     cmd_neg
);
   logic [NUM_PINS-1:0] last_open = '0;
   logic [NUM_PINS-1:0] chg       = '0;
   logic [1:0]          cnt       = 2'h0;
   // real contacts chatter, so every change bounces three cycles first
   always @(posedge aclk)
   begin
      last_open <= sw_open;
      if (sw_open != last_open)
      begin
         chg <= sw_open ^ last_open;
         cnt <= 2'h3;
      end
      else if (cnt != 2'h0)
         cnt <= cnt - 2'h1;
   end
   // closed contact conducts, high means released
   assign io_connector = ~sw_open ^ (cnt[0] ? chg : '0);
   // controller backs away from a limit by its command direction
   always @(posedge aclk)
   begin
      cmd_pos <= want[0];
      cmd_neg <= want[1];
   end
endmodule
`default_nettype wire

// file: tb/sls_top_tb.sv
// self-checking bench for the stroke limit supervision
`timescale 1ns/100ps
`default_nettype none
module sls_top_tb;
   import sls_pkg::*;
   // ==========================================================
   // settings and signals
   localparam int DEB      = 4;
   localparam int WAIT_MAX = 40;
   localparam int LIMIT    = 20000;
   logic                aclk          = 1'b0;
   logic                aresetn       = 1'b0;
   sls_axi_req_t        axi_req       = '0;
   sls_axi_rsp_t        axi_rsp;
   logic [NUM_PINS-1:0] io_connector;
   logic [NUM_PINS-1:0] sw_open       = '0;
   logic [1:0]          want          = 2'h0;
   sls_mode_t           ctl_mode      = MODE_POS;
   logic                motor_linear  = 1'b0;
   logic                pole_active   = 1'b0;
   logic                homing_done   = 1'b0;
   logic                cmd_pos;
   logic                cmd_neg;
   logic                cmd_pos_ok;
   logic                cmd_neg_ok;
   logic                stop_req;
   logic                stop_slow;
   logic [1:0]          warn;
   logic                home_lost;
   logic                irq;
   int                  err_count     = 0;
   int                  n_compared    = 0;
   int                  cycles        = 0;

   always #2 aclk = ~aclk;

   // ==========================================================
   // design and far side
   sls_top #(.DEB_COUNT(DEB)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .axi_req(axi_req), .axi_rsp(axi_rsp),
      .io_connector(io_connector), .ctl_mode(ctl_mode), .motor_linear(motor_linear),
      .pole_detect_active(pole_active), .homing_done(homing_done), .cmd_pos(cmd_pos),
      .cmd_neg(cmd_neg), .cmd_pos_ok(cmd_pos_ok), .cmd_neg_ok(cmd_neg_ok),
      .stop_req(stop_req), .stop_slow(stop_slow), .stroke_limit_warning(warn),
      .home_lost(home_lost), .irq(irq));
   sls_partner u_far (
      .aclk(aclk), .sw_open(sw_open), .want(want), .io_connector(io_connector),
      .cmd_pos(cmd_pos), .cmd_neg(cmd_neg));

   // ==========================================================
   // shared tasks
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      axi_req.awaddr  <= {24'h000000, a};
      axi_req.wdata   <= d;
      axi_req.wstrb   <= 4'hF;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid  <= 1'b1;
      axi_req.bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (axi_req.awvalid && axi_rsp.awready)
            axi_req.awvalid <= 1'b0;
         if (axi_req.wvalid && axi_rsp.wready)
            axi_req.wvalid <= 1'b0;
      end
      while (axi_rsp.bvalid !== 1'b1);
      axi_req.bready <= 1'b0;
      check(32'(axi_rsp.bresp), 32'(r));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] r);
      @(posedge aclk);
      axi_req.araddr  <= {24'h000000, a};
      axi_req.arvalid <= 1'b1;
      axi_req.rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (axi_req.arvalid && axi_rsp.arready)
            axi_req.arvalid <= 1'b0;
      end
      while (axi_rsp.rvalid !== 1'b1);
      axi_req.rready <= 1'b0;
      check(axi_rsp.rdata, exp);
      check(32'(axi_rsp.rresp), 32'(r));
   endtask

   // bounded wait, filter and sync latency is not fixed at the ports
   task automatic wait_stop(input logic v);
      int i;
      i = 0;
      while (stop_req !== v && i < WAIT_MAX)
      begin
         @(posedge aclk);
         i++;
      end
      check(32'(stop_req), 32'(v));
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // ==========================================================
   // hang guard
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         err_count++;
         report_and_stop();
      end
   end

   // ==========================================================
   // main sequence
   initial
   begin
      idle(2);
      aresetn <= 1'b1;
      rd(OFS_CTRL, 32'h00001000, RESP_OKAY);
      rd(OFS_STATUS, 32'h00000300, RESP_OKAY);
      rd(OFS_ISTAT, 32'h00000000, RESP_OKAY);
      rd(8'h10, 32'h00000000, RESP_SLVERR);
      wr(8'h10, 32'hFFFFFFFF, RESP_SLVERR);
      wr(OFS_STATUS, 32'hFFFFFFFF, RESP_OKAY);
      rd(OFS_STATUS, 32'h00000300, RESP_OKAY);
      wr(OFS_IMASK, 32'h00000007, RESP_OKAY);
      rd(OFS_IMASK, 32'h00000007, RESP_OKAY);
      // forward hit, quick stop, then back away
      want    <= 2'h1;
      sw_open <= 8'h01;
      wait_stop(1'b1);
      check(32'(warn), 32'h1);
      check(32'(cmd_pos_ok), 32'h0);
      check(32'(home_lost), 32'h1);
      check(32'(irq), 32'h1);
      rd(OFS_STATUS, 32'h00000235, RESP_OKAY);
      rd(OFS_ISTAT, 32'h00000005, RESP_OKAY);
      want <= 2'h2;
      wait_stop(1'b0);
      check(32'(cmd_neg_ok), 32'h1);
      want    <= 2'h0;
      sw_open <= 8'h00;
      idle(16);
      check(32'(warn), 32'h0);
      wr(OFS_ISTAT, 32'h00000007, RESP_OKAY);
      check(32'(irq), 32'h0);
      homing_done <= 1'b1;
      idle(1);
      homing_done <= 1'b0;
      idle(2);
      check(32'(home_lost), 32'h0);
      // reverse hit in speed mode, slow stop, warning off
      wr(OFS_CTRL, 32'h00001003, RESP_OKAY);
      ctl_mode <= MODE_SPEED;
      want     <= 2'h2;
      sw_open  <= 8'h02;
      wait_stop(1'b1);
      check(32'(warn), 32'h0);
      check(32'(stop_slow), 32'h1);
      check(32'(home_lost), 32'h0);
      check(32'(cmd_neg_ok), 32'h0);
      want <= 2'h1;
      wait_stop(1'b0);
      check(32'(cmd_pos_ok), 32'h1);
      want     <= 2'h0;
      sw_open  <= 8'h00;
      ctl_mode <= MODE_TORQUE;
      idle(16);
      // torque mode ignores limits unless linear pole detection runs
      wr(OFS_CTRL, 32'h00001000, RESP_OKAY);
      wr(OFS_ISTAT, 32'h00000007, RESP_OKAY);
      want    <= 2'h2;
      sw_open <= 8'h02;
      idle(20);
      check(32'(stop_req), 32'h0);
      motor_linear <= 1'b1;
      pole_active  <= 1'b1;
      wait_stop(1'b1);
      check(32'(warn), 32'h2);
      check(32'(cmd_neg_ok), 32'h0);
      wr(OFS_IMASK, 32'h00000000, RESP_OKAY);
      check(32'(irq), 32'h0);
      wr(OFS_IMASK, 32'h00000007, RESP_OKAY);
      check(32'(irq), 32'h1);
      want <= 2'h0;
      wr(OFS_CTRL, 32'h00001008, RESP_OKAY);
      wait_stop(1'b0);
      // let the filter close before limits count again, else a false hit follows
      sw_open      <= 8'h00;
      idle(16);
      ctl_mode     <= MODE_POS;
      motor_linear <= 1'b0;
      pole_active  <= 1'b0;
      wr(OFS_CTRL, 32'h00001000, RESP_OKAY);
      wr(OFS_ISTAT, 32'h00000007, RESP_OKAY);
      // short contact break stays below the filter
      sw_open <= 8'h01;
      idle(2);
      sw_open <= 8'h00;
      idle(20);
      check(32'(stop_req), 32'h0);
      rd(OFS_ISTAT, 32'h00000000, RESP_OKAY);
      // automatic on keeps the axis running
      wr(OFS_CTRL, 32'h00001004, RESP_OKAY);
      sw_open <= 8'h03;
      idle(20);
      check(32'(stop_req), 32'h0);
      check(32'(warn), 32'h0);
      sw_open <= 8'h00;
      idle(16);
      // forward function moved to pin 5
      wr(OFS_CTRL, 32'h00001500, RESP_OKAY);
      sw_open <= 8'h01;
      idle(20);
      check(32'(stop_req), 32'h0);
      sw_open <= 8'h20;
      wait_stop(1'b1);
      check(32'(warn), 32'h1);
      sw_open <= 8'h00;
      wait_stop(1'b0);
      report_and_stop();
   end
endmodule
`default_nettype wire
